//--- hw/switch_cfg_pkg.sv
// constants for the switch configuration register bank
// assumes one 8-bit register address space reached by the serial slave port
package switch_cfg_pkg;

  // ****************************************************
  // serial slave address
  // ****************************************************
  localparam logic [3:0] SLAVE_ADDR_UPPER = 4'h9; // fixed upper address bits

  // ****************************************************
  // register offsets
  // ****************************************************
  localparam logic [7:0] OFS_HIGH_SPEED_MODE = 8'h00;
  localparam logic [7:0] OFS_AUXILIARY_MODE = 8'h01;
  localparam logic [7:0] OFS_RECEIVER_SETTINGS = 8'h10;
  localparam logic [7:0] OFS_INPUT_TERMINATION_AB = 8'h11;
  localparam logic [7:0] OFS_INPUT_TERMINATION_CD = 8'h12;
  localparam logic [7:0] OFS_RECEIVE_EQUALIZER_AB = 8'h13;
  localparam logic [7:0] OFS_RECEIVE_EQUALIZER_CD = 8'h14;
  localparam logic [7:0] OFS_TRANSMITTER_SETTINGS = 8'h20;

  // ****************************************************
  // reset values
  // ****************************************************
  localparam logic [7:0] RST_HIGH_SPEED_MODE = 8'h40;
  localparam logic [7:0] RST_AUXILIARY_MODE = 8'h40;
  localparam logic [7:0] RST_RECEIVER_SETTINGS = 8'h01;
  localparam logic [7:0] RST_INPUT_TERMINATION = 8'h00;
  localparam logic [7:0] RST_RECEIVE_EQUALIZER = 8'h00;
  localparam logic [7:0] RST_TRANSMITTER_SETTINGS = 8'h03;

  // ****************************************************
  // field positions and writable masks
  // ****************************************************
  localparam int SWITCH_ENABLE_BIT = 6;     // both mode registers
  localparam int SOURCE_SELECT_LSB = 0;     // two bits, both mode registers
  localparam int INPUT_TERM_GLOBAL_BIT = 0;
  localparam int OUTPUT_PREEMPHASIS_LSB = 2; // two bits
  localparam int OUTPUT_TERM_ENABLE_BIT = 1;
  localparam int OUTPUT_CURRENT_LEVEL_BIT = 0;
  localparam logic [7:0] MASK_MODE = 8'h43;
  localparam logic [7:0] MASK_RECEIVER = 8'h01;
  localparam logic [7:0] MASK_TRANSMITTER = 8'h0F;

  // ****************************************************
  // serial slave states
  // ****************************************************
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ACK_ADDR = 4'h2,
    ST_REG = 4'h3,
    ST_ACK_REG = 4'h4,
    ST_WDATA = 4'h5,
    ST_ACK_WDATA = 4'h6,
    ST_RDATA = 4'h7,
    ST_ACK_RDATA = 4'h8
  } slave_state_t;

endpackage

//--- hw/switch_config_register_bank.sv
// configuration register bank of a four-input video link switch,
// written and read over a two-wire serial slave port
// assumes the serial lines and straps are synchronous to CLK_SYS and that
// the serial clock is far slower than CLK_SYS (20 MHz)
`timescale 1ns/1ns
`default_nettype none

module switch_config_register_bank
  import switch_cfg_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // serial slave port, open drain data line
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  // address straps
  input wire logic SLAVE_ADDR_STRAP2,
  input wire logic SLAVE_ADDR_STRAP1,
  input wire logic SLAVE_ADDR_STRAP0,
  // parallel control permission
  output logic PARALLEL_CTRL_ENABLE,
  // high speed and auxiliary switch settings
  output logic FAST_SWITCH_ENABLE,
  output logic [1:0] FAST_SOURCE_SELECT,
  output logic SIDE_SWITCH_ENABLE,
  output logic [1:0] SIDE_SOURCE_SELECT,
  // per-channel input termination, index is channel number within source
  output logic [3:0] INPUT_TERM_A,
  output logic [3:0] INPUT_TERM_B,
  output logic [3:0] INPUT_TERM_C,
  output logic [3:0] INPUT_TERM_D,
  // per-channel equalizer level, one is high
  output logic [3:0] INPUT_EQ_LEVEL_A,
  output logic [3:0] INPUT_EQ_LEVEL_B,
  output logic [3:0] INPUT_EQ_LEVEL_C,
  output logic [3:0] INPUT_EQ_LEVEL_D,
  // transmitter settings
  output logic [1:0] OUTPUT_PREEMPHASIS,
  output logic OUTPUT_TERM_ENABLE,
  output logic OUTPUT_CURRENT_LEVEL
);

  // ****************************************************
  // register storage and line sampling
  // ****************************************************
  logic [7:0] high_speed_mode_reg;
  logic [7:0] auxiliary_mode_reg;
  logic [7:0] receiver_settings_reg;
  logic [7:0] input_termination_ab_reg;
  logic [7:0] input_termination_cd_reg;
  logic [7:0] receive_equalizer_ab_reg;
  logic [7:0] receive_equalizer_cd_reg;
  logic [7:0] transmitter_settings_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;
  logic [2:0] strap_reg;
  slave_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic [7:0] pointer_reg;
  logic master_nack_reg;
  logic wr_strobe;
  logic [7:0] read_data;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic addr_match;

  // edge and bus condition detection on the previous sample
  assign scl_rise = SCL_IN && !scl_prev_reg;
  assign scl_fall = !SCL_IN && scl_prev_reg;
  assign start_seen = SCL_IN && scl_prev_reg && sda_prev_reg && !SDA_IN;
  assign stop_seen = SCL_IN && scl_prev_reg && !sda_prev_reg && SDA_IN;
  assign addr_match = shift_reg[7:1] == {SLAVE_ADDR_UPPER, strap_reg};
  assign wr_strobe = (state_reg == ST_WDATA) && scl_fall &&
                     (bit_cnt_reg == 4'h8);

  // previous line levels; lines idle high so reset to one
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= SCL_IN;
      sda_prev_reg <= SDA_IN;
    end
  end

  // straps are resampled every cycle so a late-settling tie is still seen
  always_ff @(posedge CLK_SYS) begin
    strap_reg <= {SLAVE_ADDR_STRAP2, SLAVE_ADDR_STRAP1,
                  SLAVE_ADDR_STRAP0};
  end

  // ****************************************************
  // register read mux
  // ****************************************************
  always_comb begin
    unique case (pointer_reg)
      OFS_HIGH_SPEED_MODE: read_data = high_speed_mode_reg;
      OFS_AUXILIARY_MODE: read_data = auxiliary_mode_reg;
      OFS_RECEIVER_SETTINGS: read_data = receiver_settings_reg;
      OFS_INPUT_TERMINATION_AB: read_data = input_termination_ab_reg;
      OFS_INPUT_TERMINATION_CD: read_data = input_termination_cd_reg;
      OFS_RECEIVE_EQUALIZER_AB: read_data = receive_equalizer_ab_reg;
      OFS_RECEIVE_EQUALIZER_CD: read_data = receive_equalizer_cd_reg;
      OFS_TRANSMITTER_SETTINGS: read_data = transmitter_settings_reg;
      default: read_data = 8'h00; // unmapped reads as zero
    endcase
  end

  // ****************************************************
  // serial slave sequencer
  // ****************************************************
  // start and stop win over bit traffic in any state
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      master_nack_reg <= 1'b0;
      SDA_OE <= 1'b0;
    end else if (start_seen) begin
      state_reg <= ST_ADDR;
      bit_cnt_reg <= 4'h0;
      SDA_OE <= 1'b0;
    end else if (stop_seen) begin
      state_reg <= ST_IDLE;
      SDA_OE <= 1'b0;
    end else if (scl_rise) begin
      // data is taken while the clock is high
      if (state_reg == ST_ACK_RDATA) begin
        master_nack_reg <= SDA_IN;
      end else if (state_reg inside {ST_ADDR, ST_REG, ST_WDATA,
                                     ST_RDATA}) begin
        // acknowledge bits stay out of the shifter, so the direction
        // bit is still at bit 0 when the acknowledge clock falls
        shift_reg <= {shift_reg[6:0], SDA_IN};
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
    end else if (scl_fall) begin
      // the slave only changes the data line while the clock is low
      unique case (state_reg)
        ST_IDLE: begin
          SDA_OE <= 1'b0;
        end
        ST_ADDR: begin
          if (bit_cnt_reg == 4'h8) begin
            state_reg <= addr_match ? ST_ACK_ADDR : ST_IDLE;
            SDA_OE <= addr_match;
          end
        end
        ST_ACK_ADDR: begin
          bit_cnt_reg <= 4'h0;
          if (shift_reg[0]) begin
            state_reg <= ST_RDATA;
            tx_reg <= read_data;
            SDA_OE <= !read_data[7];
          end else begin
            state_reg <= ST_REG;
            SDA_OE <= 1'b0;
          end
        end
        ST_REG: begin
          if (bit_cnt_reg == 4'h8) begin
            state_reg <= ST_ACK_REG;
            SDA_OE <= 1'b1;
          end
        end
        ST_ACK_REG, ST_ACK_WDATA: begin
          state_reg <= ST_WDATA;
          bit_cnt_reg <= 4'h0;
          SDA_OE <= 1'b0;
        end
        ST_WDATA: begin
          if (bit_cnt_reg == 4'h8) begin
            state_reg <= ST_ACK_WDATA;
            SDA_OE <= 1'b1;
          end
        end
        ST_RDATA: begin
          if (bit_cnt_reg == 4'h8) begin
            state_reg <= ST_ACK_RDATA;
            SDA_OE <= 1'b0;
          end else begin
            tx_reg <= {tx_reg[6:0], 1'b0};
            SDA_OE <= !tx_reg[6];
          end
        end
        ST_ACK_RDATA: begin
          // repeated reads keep returning the same register
          bit_cnt_reg <= 4'h0;
          if (master_nack_reg) begin
            state_reg <= ST_IDLE;
            SDA_OE <= 1'b0;
          end else begin
            state_reg <= ST_RDATA;
            tx_reg <= read_data;
            SDA_OE <= !read_data[7];
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          SDA_OE <= 1'b0;
        end
      endcase
    end
  end

  // pointer captured after the register address byte
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      pointer_reg <= 8'h00;
    end else if (state_reg == ST_REG && scl_fall && bit_cnt_reg == 4'h8) begin
      pointer_reg <= shift_reg;
    end
  end

  // open drain: the driven level is always low
  always_ff @(posedge CLK_SYS) begin
    SDA_OUT <= 1'b0;
  end

  // parallel control dies on the first transfer addressed to this slave
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      PARALLEL_CTRL_ENABLE <= 1'b1;
    end else if (state_reg == ST_ADDR && scl_fall && bit_cnt_reg == 4'h8 &&
                 addr_match) begin
      PARALLEL_CTRL_ENABLE <= 1'b0;
    end
  end

  // ****************************************************
  // register writes
  // ****************************************************
  // reserved bits are masked at write time so they always read zero
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      high_speed_mode_reg <= RST_HIGH_SPEED_MODE;
      auxiliary_mode_reg <= RST_AUXILIARY_MODE;
      receiver_settings_reg <= RST_RECEIVER_SETTINGS;
      input_termination_ab_reg <= RST_INPUT_TERMINATION;
      input_termination_cd_reg <= RST_INPUT_TERMINATION;
      receive_equalizer_ab_reg <= RST_RECEIVE_EQUALIZER;
      receive_equalizer_cd_reg <= RST_RECEIVE_EQUALIZER;
      transmitter_settings_reg <= RST_TRANSMITTER_SETTINGS;
    end else if (wr_strobe) begin
      unique case (pointer_reg)
        OFS_HIGH_SPEED_MODE: high_speed_mode_reg <= shift_reg & MASK_MODE;
        OFS_AUXILIARY_MODE: auxiliary_mode_reg <= shift_reg & MASK_MODE;
        OFS_RECEIVER_SETTINGS:
          receiver_settings_reg <= shift_reg & MASK_RECEIVER;
        OFS_INPUT_TERMINATION_AB: input_termination_ab_reg <= shift_reg;
        OFS_INPUT_TERMINATION_CD: input_termination_cd_reg <= shift_reg;
        OFS_RECEIVE_EQUALIZER_AB: receive_equalizer_ab_reg <= shift_reg;
        OFS_RECEIVE_EQUALIZER_CD: receive_equalizer_cd_reg <= shift_reg;
        OFS_TRANSMITTER_SETTINGS:
          transmitter_settings_reg <= shift_reg & MASK_TRANSMITTER;
        default: ; // writes to unmapped addresses are dropped
      endcase
    end
  end

  // ****************************************************
  // control outputs
  // ****************************************************
  // registered copies keep every output straight from a flip-flop
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      FAST_SWITCH_ENABLE <= RST_HIGH_SPEED_MODE[SWITCH_ENABLE_BIT];
      FAST_SOURCE_SELECT <= RST_HIGH_SPEED_MODE[SOURCE_SELECT_LSB +: 2];
      SIDE_SWITCH_ENABLE <= RST_AUXILIARY_MODE[SWITCH_ENABLE_BIT];
      SIDE_SOURCE_SELECT <= RST_AUXILIARY_MODE[SOURCE_SELECT_LSB +: 2];
      OUTPUT_PREEMPHASIS <=
        RST_TRANSMITTER_SETTINGS[OUTPUT_PREEMPHASIS_LSB +: 2];
      OUTPUT_TERM_ENABLE <= RST_TRANSMITTER_SETTINGS[OUTPUT_TERM_ENABLE_BIT];
      OUTPUT_CURRENT_LEVEL <=
        RST_TRANSMITTER_SETTINGS[OUTPUT_CURRENT_LEVEL_BIT];
    end else begin
      FAST_SWITCH_ENABLE <= high_speed_mode_reg[SWITCH_ENABLE_BIT];
      FAST_SOURCE_SELECT <=
        high_speed_mode_reg[SOURCE_SELECT_LSB +: 2];
      SIDE_SWITCH_ENABLE <= auxiliary_mode_reg[SWITCH_ENABLE_BIT];
      SIDE_SOURCE_SELECT <=
        auxiliary_mode_reg[SOURCE_SELECT_LSB +: 2];
      OUTPUT_PREEMPHASIS <=
        transmitter_settings_reg[OUTPUT_PREEMPHASIS_LSB +: 2];
      OUTPUT_TERM_ENABLE <=
        transmitter_settings_reg[OUTPUT_TERM_ENABLE_BIT];
      OUTPUT_CURRENT_LEVEL <=
        transmitter_settings_reg[OUTPUT_CURRENT_LEVEL_BIT];
    end
  end

  // per-channel fan-out; C and D run in reverse bit order
  for (genvar ch = 0; ch < 4; ch++) begin : g_chan
    always_ff @(posedge CLK_SYS) begin
      if (RST) begin
        INPUT_TERM_A[ch] <= 1'b0;
        INPUT_TERM_B[ch] <= 1'b0;
        INPUT_TERM_C[ch] <= 1'b0;
        INPUT_TERM_D[ch] <= 1'b0;
        INPUT_EQ_LEVEL_A[ch] <= 1'b0;
        INPUT_EQ_LEVEL_B[ch] <= 1'b0;
        INPUT_EQ_LEVEL_C[ch] <= 1'b0;
        INPUT_EQ_LEVEL_D[ch] <= 1'b0;
      end else begin
        // global select low opens every switch
        INPUT_TERM_A[ch] <= receiver_settings_reg[INPUT_TERM_GLOBAL_BIT] &&
                            input_termination_ab_reg[4 + ch];
        INPUT_TERM_B[ch] <= receiver_settings_reg[INPUT_TERM_GLOBAL_BIT] &&
                            input_termination_ab_reg[ch];
        INPUT_TERM_C[ch] <= receiver_settings_reg[INPUT_TERM_GLOBAL_BIT] &&
                            input_termination_cd_reg[3 - ch];
        INPUT_TERM_D[ch] <= receiver_settings_reg[INPUT_TERM_GLOBAL_BIT] &&
                            input_termination_cd_reg[7 - ch];
        INPUT_EQ_LEVEL_A[ch] <= receive_equalizer_ab_reg[4 + ch];
        INPUT_EQ_LEVEL_B[ch] <= receive_equalizer_ab_reg[ch];
        INPUT_EQ_LEVEL_C[ch] <= receive_equalizer_cd_reg[3 - ch];
        INPUT_EQ_LEVEL_D[ch] <= receive_equalizer_cd_reg[7 - ch];
      end
    end
  end

endmodule

`default_nettype wire

//--- testbench/switch_cfg_properties.sv
// port checker for the switch configuration register bank
// assumes a serial master that holds each SCL level 4 or more cycles
`timescale 1ns/1ns
`default_nettype none
module switch_cfg_properties (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // serial port
  input wire logic SCL_IN,
  input wire logic SDA_OUT,
  input wire logic SDA_OE,
  // settings
  input wire logic PARALLEL_CTRL_ENABLE,
  input wire logic FAST_SWITCH_ENABLE,
  input wire logic [1:0] FAST_SOURCE_SELECT,
  input wire logic SIDE_SWITCH_ENABLE,
  input wire logic [1:0] SIDE_SOURCE_SELECT,
  input wire logic [3:0] INPUT_TERM_A,
  input wire logic [3:0] INPUT_TERM_B,
  input wire logic [3:0] INPUT_TERM_C,
  input wire logic [3:0] INPUT_TERM_D,
  input wire logic [3:0] INPUT_EQ_LEVEL_A,
  input wire logic [3:0] INPUT_EQ_LEVEL_B,
  input wire logic [3:0] INPUT_EQ_LEVEL_C,
  input wire logic [3:0] INPUT_EQ_LEVEL_D,
  input wire logic [1:0] OUTPUT_PREEMPHASIS,
  input wire logic OUTPUT_TERM_ENABLE,
  input wire logic OUTPUT_CURRENT_LEVEL
);
  // ****************************************
  // properties
  // ****************************************
  logic [31:0] inputs;
  logic [41:0] cfg;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  // all settings but the parallel enable in one word, so any change is caught
  assign inputs = {INPUT_TERM_A, INPUT_TERM_B, INPUT_TERM_C, INPUT_TERM_D,
    INPUT_EQ_LEVEL_A, INPUT_EQ_LEVEL_B, INPUT_EQ_LEVEL_C, INPUT_EQ_LEVEL_D};
  assign cfg = {FAST_SWITCH_ENABLE, FAST_SOURCE_SELECT, SIDE_SWITCH_ENABLE,
    SIDE_SOURCE_SELECT, inputs, OUTPUT_PREEMPHASIS, OUTPUT_TERM_ENABLE,
    OUTPUT_CURRENT_LEVEL};
  chk_reset_modes: assert property (
    $fell(RST) |-> FAST_SWITCH_ENABLE && SIDE_SWITCH_ENABLE &&
    FAST_SOURCE_SELECT == 2'h0 && SIDE_SOURCE_SELECT == 2'h0)
    else $error("mode settings wrong after reset");
  chk_reset_inputs: assert property (
    $fell(RST) |-> inputs == 32'h0)
    else $error("input settings wrong after reset");
  chk_reset_output: assert property ($fell(RST) |->
    {OUTPUT_PREEMPHASIS, OUTPUT_TERM_ENABLE, OUTPUT_CURRENT_LEVEL} == 4'h3)
    else $error("output settings wrong after reset");
  chk_reset_parallel: assert property (
    $fell(RST) |-> PARALLEL_CTRL_ENABLE)
    else $error("parallel control off after reset");
  chk_parallel_stays_off: assert property (!PARALLEL_CTRL_ENABLE |=>
    !PARALLEL_CTRL_ENABLE) else $error("parallel control came back");
  // settings move only while the slave acknowledges a data byte
  chk_update_at_ack: assert property (
    $changed(cfg) |-> SDA_OE && !SCL_IN)
    else $error("settings changed outside a serial write");
  chk_sda_out_low: assert property (!SDA_OUT)
    else $error("data line driven high");
  chk_oe_after_fall: assert property ($changed(SDA_OE) |->
    !$past(SCL_IN) && $past(SCL_IN, 2))
    else $error("data line drive changed off the clock fall");
  chk_oe_holds_low: assert property ($rose(SDA_OE) |-> SDA_OE [*6])
    else $error("data line released too early");
endmodule
bind switch_config_register_bank switch_cfg_properties chk (
  .CLK_SYS(CLK_SYS), .RST(RST), .SCL_IN(SCL_IN), .SDA_OUT(SDA_OUT),
  .SDA_OE(SDA_OE), .PARALLEL_CTRL_ENABLE(PARALLEL_CTRL_ENABLE),
  .FAST_SWITCH_ENABLE(FAST_SWITCH_ENABLE),
  .FAST_SOURCE_SELECT(FAST_SOURCE_SELECT),
  .SIDE_SWITCH_ENABLE(SIDE_SWITCH_ENABLE),
  .SIDE_SOURCE_SELECT(SIDE_SOURCE_SELECT), .INPUT_TERM_A(INPUT_TERM_A),
  .INPUT_TERM_B(INPUT_TERM_B), .INPUT_TERM_C(INPUT_TERM_C),
  .INPUT_TERM_D(INPUT_TERM_D), .INPUT_EQ_LEVEL_A(INPUT_EQ_LEVEL_A),
  .INPUT_EQ_LEVEL_B(INPUT_EQ_LEVEL_B), .INPUT_EQ_LEVEL_C(INPUT_EQ_LEVEL_C),
  .INPUT_EQ_LEVEL_D(INPUT_EQ_LEVEL_D),
  .OUTPUT_PREEMPHASIS(OUTPUT_PREEMPHASIS),
  .OUTPUT_TERM_ENABLE(OUTPUT_TERM_ENABLE),
  .OUTPUT_CURRENT_LEVEL(OUTPUT_CURRENT_LEVEL));
`default_nettype wire

//--- testbench/serial_master_model.sv
// two-wire serial master model for the register bank's slave port
// assumes a pull-up on the data line; the slave pulls it low via sda_oe
`timescale 1ns/1ns
`default_nettype none
module serial_master_model (
  // clock
  input wire logic clk,
  // slave pull-down
  input wire logic sda_oe,
  // bus lines
  output logic scl,
  output wire logic sda_wire,
  // received byte or acknowledge bit, one strobe each
  output logic got_valid,
  output logic [7:0] got_value
);
  // ****************************************
  // bus driving
  // ****************************************
  logic sda_low;
  int half = 4; // cycles per hold step; the clock is high one step and low two; raised by the bench to go slow
  // a released line floats up to the pull-up level
  assign sda_wire = (sda_low || sda_oe) ? 1'b0 : 1'b1;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    got_valid = 1'b0;
    got_value = 8'h00;
  end
  task automatic hold();
    repeat (half) @(negedge clk);
  endtask
  // start or repeated start: data falls while the clock is high
  task automatic start();
    sda_low = 1'b0;
    hold();
    scl = 1'b1;
    hold();
    sda_low = 1'b1;
    hold();
    scl = 1'b0;
    hold();
  endtask
  task automatic stop();
    sda_low = 1'b1;
    hold();
    scl = 1'b1;
    hold();
    sda_low = 1'b0;
    hold();
  endtask
  // data only moves while the clock is low
  task automatic bit_cycle(input logic b, output logic s);
    sda_low = !b;
    hold();
    scl = 1'b1;
    hold();
    s = sda_wire;
    scl = 1'b0;
    hold();
  endtask
  // eight bits msb first, then a ninth bit: the slave's ack in, or the
  // master's nack (released) or ack (pulled low, when more is set) out
  task automatic xfer(input logic [7:0] tx, input logic reading,
    input logic more = 1'b0);
    logic s;
    logic [7:0] rx;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(tx[i], s);
      rx[i] = s;
    end
    bit_cycle(!more, s);
    got_value = reading ? rx : {7'h00, s};
    got_valid = 1'b1;
    @(negedge clk);
    got_valid = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- testbench/switch_config_register_bank_test.sv
// self-checking bench for the switch configuration register bank
// assumes the serial master model and the port checker are compiled too
`timescale 1ns/1ns
`default_nettype none
module switch_config_register_bank_test;
  import switch_cfg_pkg::*;
  // ****************************************
  // signals and bookkeeping
  // ****************************************
  localparam logic [7:0] REG_OFS [8] = '{OFS_HIGH_SPEED_MODE,
    OFS_AUXILIARY_MODE, OFS_RECEIVER_SETTINGS, OFS_INPUT_TERMINATION_AB,
    OFS_INPUT_TERMINATION_CD, OFS_RECEIVE_EQUALIZER_AB,
    OFS_RECEIVE_EQUALIZER_CD, OFS_TRANSMITTER_SETTINGS};
  localparam logic [7:0] REG_RST [8] = '{RST_HIGH_SPEED_MODE,
    RST_AUXILIARY_MODE, RST_RECEIVER_SETTINGS, RST_INPUT_TERMINATION,
    RST_INPUT_TERMINATION, RST_RECEIVE_EQUALIZER, RST_RECEIVE_EQUALIZER,
    RST_TRANSMITTER_SETTINGS};
  localparam logic [7:0] REG_MASK [8] = '{MASK_MODE, MASK_MODE,
    MASK_RECEIVER, 8'hFF, 8'hFF, 8'hFF, 8'hFF, MASK_TRANSMITTER};
  logic clk_sys, rst, scl, got_valid, sda_oe, pce, fast_en, side_en;
  logic [2:0] strap;
  logic [7:0] got_value, d;
  logic [1:0] fast_sel, side_sel, pe;
  logic te, cl;
  logic [3:0] ta, tb, tc, td, ea, eb, ec, ed;
  wire logic sda_wire;
  logic [7:0] shadow [8];
  logic [7:0] expq [$];
  logic [31:0] rnd;
  int checks = 0;
  int mismatches = 0;
  int cycles = 0;
  serial_master_model m (.clk(clk_sys), .sda_oe(sda_oe), .scl(scl),
    .sda_wire(sda_wire), .got_valid(got_valid), .got_value(got_value));
  switch_config_register_bank dut (.CLK_SYS(clk_sys), .RST(rst),
    .SCL_IN(scl), .SDA_IN(sda_wire), .SDA_OUT(), .SDA_OE(sda_oe),
    .SLAVE_ADDR_STRAP2(strap[2]), .SLAVE_ADDR_STRAP1(strap[1]),
    .SLAVE_ADDR_STRAP0(strap[0]), .PARALLEL_CTRL_ENABLE(pce),
    .FAST_SWITCH_ENABLE(fast_en), .FAST_SOURCE_SELECT(fast_sel),
    .SIDE_SWITCH_ENABLE(side_en), .SIDE_SOURCE_SELECT(side_sel),
    .INPUT_TERM_A(ta), .INPUT_TERM_B(tb), .INPUT_TERM_C(tc),
    .INPUT_TERM_D(td), .INPUT_EQ_LEVEL_A(ea), .INPUT_EQ_LEVEL_B(eb),
    .INPUT_EQ_LEVEL_C(ec), .INPUT_EQ_LEVEL_D(ed), .OUTPUT_PREEMPHASIS(pe),
    .OUTPUT_TERM_ENABLE(te), .OUTPUT_CURRENT_LEVEL(cl));
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [3:0] rev4(input logic [3:0] v);
    return {v[0], v[1], v[2], v[3]};
  endfunction
  task automatic check(input string what, input logic [63:0] exp,
    input logic [63:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic next_rnd();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
  endtask
  task automatic send(input logic [7:0] b, input logic [7:0] e);
    expq.push_back(e);
    m.xfer(b, 1'b0);
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [7:0] v);
    m.start();
    send({SLAVE_ADDR_UPPER, strap, 1'b0}, 8'h00);
    send(ofs, 8'h00);
    send(v, 8'h00);
    m.stop();
  endtask
  // pointer write, repeated start, one byte read and a nack
  task automatic rd(input logic [7:0] ofs, input logic [7:0] e);
    m.start();
    send({SLAVE_ADDR_UPPER, strap, 1'b0}, 8'h00);
    send(ofs, 8'h00);
    m.start();
    send({SLAVE_ADDR_UPPER, strap, 1'b1}, 8'h00);
    expq.push_back(e);
    m.xfer(8'hFF, 1'b1);
    m.stop();
  endtask
  // expected pins worked out from the shadow copy of the registers
  task automatic check_outputs();
    logic [3:0] g;
    g = {4{shadow[2][0]}};
    check("settings", {shadow[0][6], shadow[0][1:0], shadow[1][6],
      shadow[1][1:0], g & shadow[3][7:4], g & shadow[3][3:0],
      g & rev4(shadow[4][3:0]), g & rev4(shadow[4][7:4]), shadow[5][7:4],
      shadow[5][3:0], rev4(shadow[6][3:0]), rev4(shadow[6][7:4]),
      shadow[7][3:0]}, {fast_en, fast_sel, side_en, side_sel, ta, tb, tc,
      td, ea, eb, ec, ed, pe, te, cl});
  endtask
  task automatic do_reset();
    rst = 1'b1;
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    shadow = REG_RST;
    @(negedge clk_sys);
  endtask
  // ****************************************
  // clock, timeout, result monitor, sequence
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches++;
      complete_run();
    end
  end
  always @(posedge got_valid) begin
    check("serial result", expq.pop_front(), got_value);
  end
  initial begin
    rst = 1'b1;
    rnd = 32'h00000051;
    next_rnd();
    strap = rnd[2:0];
    do_reset();
    check_outputs();
    // a foreign address gets no ack and must not count as first use
    m.start();
    send({~SLAVE_ADDR_UPPER, strap, 1'b0}, 8'h01);
    m.stop();
    check("parallel enable", 64'h1, pce);
    for (int i = 0; i < 8; i++) begin
      rd(REG_OFS[i], REG_RST[i]);
    end
    check("parallel enable", 64'h0, pce);
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 8; i++) begin
        next_rnd();
        d = rnd[7:0];
        if (i < 2) d = {d[7], k[1], d[5:2], k[1:0]};
        if (i == 2) d[0] = k[0];
        if (i == 7) d[3:2] = k[1:0];
        shadow[i] = d & REG_MASK[i];
        wr(REG_OFS[i], d);
        rd(REG_OFS[i], shadow[i]);
        check_outputs();
      end
    end
    // master ack repeats the register the pointer still holds; nack ends
    m.start();
    send({SLAVE_ADDR_UPPER, strap, 1'b1}, 8'h00);
    expq.push_back(shadow[7]);
    m.xfer(8'hFF, 1'b1, 1'b1);
    expq.push_back(shadow[7]);
    m.xfer(8'hFF, 1'b1);
    m.stop();
    // slow master on an unmapped address: data dropped, reads zero
    m.half = 9;
    wr(8'h02, 8'hA5);
    rd(8'h02, 8'h00);
    m.half = 4;
    check_outputs();
    do_reset();
    check_outputs();
    check("parallel enable", 64'h1, pce);
    complete_run();
  end
endmodule
`default_nettype wire
